// ===== design/vsa_map.vh
`ifndef VSA_MAP_VH
`define VSA_MAP_VH

// register byte addresses
`define VSA_OFS_BVANC 8'h00
`define VSA_OFS_SUBPIC 8'h04
`define VSA_OFS_TLUMA 8'h08
`define VSA_OFS_BLUMA 8'h0C
`define VSA_OFS_TCHROMA 8'h10
`define VSA_OFS_BCHROMA 8'h14
`define VSA_OFS_LINEOFS 8'h18
`define VSA_OFS_CTRL 8'h1C
`define VSA_OFS_STATUS 8'h20

// sub-picture register fields
`define VSA_HSTART_HI 23
`define VSA_HSTART_LO 16
`define VSA_WIDTH_HI 8
`define VSA_WIDTH_LO 0
`define VSA_SUBPIC_WMASK 32'h00FF01FF

// control register bits
`define VSA_CTRL_SUBPIC 0
`define VSA_CTRL_YC 1
`define VSA_CTRL_PROG 2

// reset values
`define VSA_RST_WORD 32'h00000000
`define VSA_RST_CTRL 3'h0

// fetch kinds
`define VSA_KIND_VANC 2'h0
`define VSA_KIND_LUMA 2'h1
`define VSA_KIND_CHROMA 2'h2

// smallest sub-picture width shift (16 bytes)
`define VSA_MIN_SHIFT 4'h4
`endif

// ===== design/vsa_fifo.v
`timescale 1ns/100ps
module vsa_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 32
) (
  input wire clk_sys,
  input wire rst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output reg [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);
  localparam PW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wrPtr_r;
  reg [PW-1:0] rdPtr_r;
  reg [PW:0] count_r;
  wire doWr;
  wire doRd;

  // output stage is a register so the consumer sees flop-driven data
  assign inReady = (count_r != DEPTH[PW:0]);
  assign doWr = inValid && inReady;
  assign doRd = (count_r != {(PW+1){1'b0}}) && (!outValid || outReady);

  // storage has no reset; pointers, fill level and output register carry state
  always @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // pointers, fill level and output register
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_r <= {PW{1'b0}};
      rdPtr_r <= {PW{1'b0}};
      count_r <= {(PW+1){1'b0}};
      outData <= {WIDTH{1'b0}};
      outValid <= 1'b0;
    end else begin
      if (doWr) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= rdPtr_r + 1'b1;
        outData <= mem[rdPtr_r];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      if (doWr && !doRd) begin
        count_r <= count_r + 1'b1;
      end else if (doRd && !doWr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // vsa_fifo

// ===== design/vsa_subpic_addr.v
`timescale 1ns/100ps
`include "vsa_map.vh"
module vsa_subpic_addr #(
  parameter LW = 11,
  parameter FD = 32
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  input wire fieldStart,
  input wire fieldIsBottom,
  input wire lineReq,
  input wire [LW-1:0] lineNum,
  output reg lineBusy,
  output wire [31:0] fetchAddr,
  output wire [1:0] fetchKind,
  output wire fetchValid,
  input wire fetchReady
);
  localparam ST_IDLE = 2'h0;
  localparam ST_VANC = 2'h1;
  localparam ST_LUMA = 2'h2;
  localparam ST_CHROMA = 2'h3;

  // software-visible registers
  reg [31:0] bvanc_r;
  reg [31:0] subpic_r;
  reg [31:0] tLuma_r;
  reg [31:0] bLuma_r;
  reg [31:0] tChroma_r;
  reg [31:0] bChroma_r;
  reg [31:0] lineOfs_r;
  reg [2:0] ctrl_r;

  // field shadows, frozen for the whole field
  reg [31:0] shVanc_r;
  reg [31:0] shLuma_r;
  reg [31:0] shChroma_r;
  reg [31:0] shLineOfs_r;
  reg [7:0] shHStart_r;
  reg [3:0] shShift_r;
  reg shSubpic_r;
  reg shBottom_r;

  // fetch sequencer
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [LW-1:0] line_r;
  reg pend_r;
  reg [LW-1:0] pendLine_r;
  reg busy_nxt;

  reg [31:0] lineStep;
  reg [31:0] entAddr;
  reg [1:0] entKind;
  reg entValid;
  wire entReady;
  wire entTake;
  wire [33:0] fifoOut;
  wire [3:0] widthShift;
  wire useSubpic;
  wire [31:0] status;

  // map the one-hot width code to a shift; reserved codes fall to 16 bytes
  function [3:0] widthLog2;
    input [8:0] code;
    begin
      case (code)
        9'h010: begin
          widthLog2 = 4'h4;
        end
        9'h020: begin
          widthLog2 = 4'h5;
        end
        9'h040: begin
          widthLog2 = 4'h6;
        end
        9'h080: begin
          widthLog2 = 4'h7;
        end
        9'h100: begin
          widthLog2 = 4'h8;
        end
        default: begin
          widthLog2 = `VSA_MIN_SHIFT;
        end
      endcase
    end
  endfunction

  assign widthShift = widthLog2(subpic_r[`VSA_WIDTH_HI:`VSA_WIDTH_LO]);
  // width only matters in sub-picture storage of Y/C data
  assign useSubpic = ctrl_r[`VSA_CTRL_SUBPIC] &&
    ctrl_r[`VSA_CTRL_YC];

  // register writes; reserved sub-picture bits are never stored
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bvanc_r <= `VSA_RST_WORD;
      subpic_r <= `VSA_RST_WORD;
      tLuma_r <= `VSA_RST_WORD;
      bLuma_r <= `VSA_RST_WORD;
      tChroma_r <= `VSA_RST_WORD;
      bChroma_r <= `VSA_RST_WORD;
      lineOfs_r <= `VSA_RST_WORD;
      ctrl_r <= `VSA_RST_CTRL;
    end else if (regWr) begin
      case (regAddr)
        `VSA_OFS_BVANC: begin
          bvanc_r <= regWrData;
        end
        `VSA_OFS_SUBPIC: begin
          subpic_r <= regWrData & `VSA_SUBPIC_WMASK;
        end
        `VSA_OFS_TLUMA: begin
          tLuma_r <= regWrData;
        end
        `VSA_OFS_BLUMA: begin
          bLuma_r <= regWrData;
        end
        `VSA_OFS_TCHROMA: begin
          tChroma_r <= regWrData;
        end
        `VSA_OFS_BCHROMA: begin
          bChroma_r <= regWrData;
        end
        `VSA_OFS_LINEOFS: begin
          lineOfs_r <= regWrData;
        end
        `VSA_OFS_CTRL: begin
          ctrl_r <= regWrData[2:0];
        end
        default: begin
          bvanc_r <= bvanc_r;
        end
      endcase
    end
  end

  assign status = {24'h000000, 1'b0, shBottom_r, shSubpic_r, pend_r,
    lineBusy, 1'b0, state_r};

  // read data lands the cycle after the strobe; unmapped reads give zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= `VSA_RST_WORD;
    end else if (regRd) begin
      case (regAddr)
        `VSA_OFS_BVANC: begin
          regRdData <= bvanc_r;
        end
        `VSA_OFS_SUBPIC: begin
          regRdData <= subpic_r & `VSA_SUBPIC_WMASK;
        end
        `VSA_OFS_TLUMA: begin
          regRdData <= tLuma_r;
        end
        `VSA_OFS_BLUMA: begin
          regRdData <= bLuma_r;
        end
        `VSA_OFS_TCHROMA: begin
          regRdData <= tChroma_r;
        end
        `VSA_OFS_BCHROMA: begin
          regRdData <= bChroma_r;
        end
        `VSA_OFS_LINEOFS: begin
          regRdData <= lineOfs_r;
        end
        `VSA_OFS_CTRL: begin
          regRdData <= {29'h00000000, ctrl_r};
        end
        `VSA_OFS_STATUS: begin
          regRdData <= status;
        end
        default: begin
          regRdData <= `VSA_RST_WORD;
        end
      endcase
    end else begin
      regRdData <= `VSA_RST_WORD;
    end
  end

  // snapshot at field start so a mid-field write cannot mix settings
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shVanc_r <= `VSA_RST_WORD;
      shLuma_r <= `VSA_RST_WORD;
      shChroma_r <= `VSA_RST_WORD;
      shLineOfs_r <= `VSA_RST_WORD;
      shHStart_r <= 8'h00;
      shShift_r <= `VSA_MIN_SHIFT;
      shSubpic_r <= 1'b0;
      shBottom_r <= 1'b0;
    end else if (fieldStart) begin
      shVanc_r <= bvanc_r;
      // one width for luma and chroma of either field
      shShift_r <= widthShift;
      shHStart_r <= subpic_r[`VSA_HSTART_HI:`VSA_HSTART_LO];
      shLuma_r <= fieldIsBottom ? bLuma_r : tLuma_r;
      shChroma_r <= fieldIsBottom ? bChroma_r : tChroma_r;
      shLineOfs_r <= lineOfs_r;
      shSubpic_r <= useSubpic;
      shBottom_r <= fieldIsBottom;
    end
  end

  // per-line step: raster uses the offset, sub-picture the tile width
  always @* begin
    lineStep = 32'h00000000;
    if (shSubpic_r) begin
      lineStep = {{(32-LW){1'b0}}, line_r} << shShift_r;
    end else begin
      lineStep = shLineOfs_r * {{(32-LW){1'b0}}, line_r};
    end
  end

  // entry offered to the fifo in each state
  always @* begin
    entAddr = 32'h00000000;
    entKind = `VSA_KIND_VANC;
    entValid = 1'b0;
    case (state_r)
      ST_VANC: begin
        entAddr = shVanc_r;
        entKind = `VSA_KIND_VANC;
        entValid = 1'b1;
      end
      ST_LUMA: begin
        // horizontal start displaces from the area start, in bytes
        entAddr = shLuma_r + {24'h000000, shHStart_r} + lineStep;
        entKind = `VSA_KIND_LUMA;
        entValid = 1'b1;
      end
      ST_CHROMA: begin
        entAddr = shChroma_r + {24'h000000, shHStart_r} + lineStep;
        entKind = `VSA_KIND_CHROMA;
        entValid = 1'b1;
      end
      default: begin
        entValid = 1'b0;
      end
    endcase
  end

  assign entTake = entValid && entReady;

  // next state; a full fifo simply holds the sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (fieldStart) begin
          // progressive fields still fetch the bottom ancillary area
          if (fieldIsBottom || ctrl_r[`VSA_CTRL_PROG]) begin
            state_nxt = ST_VANC;
          end else begin
            state_nxt = ST_LUMA;
          end
        end else if (pend_r || lineReq) begin
          state_nxt = ST_LUMA;
        end
      end
      ST_VANC: begin
        if (entTake) begin
          state_nxt = ST_LUMA;
        end
      end
      ST_LUMA: begin
        if (entTake) begin
          state_nxt = ST_CHROMA;
        end
      end
      ST_CHROMA: begin
        if (entTake) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // busy also covers a request that arrives or still waits, so software
  // never sees an idle gap between a finished line and a queued one
  always @* begin
    busy_nxt = (state_nxt != ST_IDLE) || lineReq || pend_r;
  end

  // sequencer registers; one line request may wait while busy
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      line_r <= {LW{1'b0}};
      pend_r <= 1'b0;
      pendLine_r <= {LW{1'b0}};
      lineBusy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lineBusy <= busy_nxt;
      if (state_r == ST_IDLE && fieldStart) begin
        line_r <= {LW{1'b0}};
        if (lineReq) begin
          pend_r <= 1'b1;
          pendLine_r <= lineNum;
        end
      end else if (state_r == ST_IDLE && pend_r) begin
        line_r <= pendLine_r;
        // a new request in the same cycle waits in the slot the taken one leaves
        pend_r <= lineReq;
        pendLine_r <= lineNum;
      end else if (state_r == ST_IDLE && lineReq) begin
        line_r <= lineNum;
      end else if (lineReq) begin
        pend_r <= 1'b1;
        pendLine_r <= lineNum;
      end
    end
  end

  // address queue toward the memory reader
  vsa_fifo #(
    .WIDTH(34),
    .DEPTH(FD)
  ) uFifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inData({entKind, entAddr}),
    .inValid(entValid),
    .inReady(entReady),
    .outData(fifoOut),
    .outValid(fetchValid),
    .outReady(fetchReady)
  );

  assign fetchAddr = fifoOut[31:0];
  assign fetchKind = fifoOut[33:32];
endmodule // vsa_subpic_addr

// ===== test/vsa_checker.sv
`timescale 1ns/100ps
`include "vsa_map.vh"
module vsa_checker (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] regAddr,
  input wire regRd,
  input wire [31:0] regRdData,
  input wire fieldStart,
  input wire fieldIsBottom,
  input wire lineReq,
  input wire lineBusy,
  input wire [31:0] fetchAddr,
  input wire [1:0] fetchKind,
  input wire fetchValid,
  input wire fetchReady
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // idle starts: nothing queued, so the first word out is the new one
  sequence bot_go;
    fieldStart && fieldIsBottom && !lineBusy && !fetchValid;
  endsequence
  sequence line_go;
    lineReq && !lineBusy && !fetchValid;
  endsequence
  sequence luma_taken;
    fetchValid && fetchReady && fetchKind == `VSA_KIND_LUMA;
  endsequence
  a_rd_idle_zero: assert property (regRdData != 32'h0 |->
    $past(regRd))
    else $error("read data outside a read cycle");
  a_subpic_resv: assert property (regRd && regAddr == 8'h04 |=>
    (regRdData & 32'hFF00FE00) == 32'h0)
    else $error("reserved sub-picture bits not zero");
  a_fetch_hold: assert property (fetchValid && !fetchReady |=>
    fetchValid && $stable(fetchAddr) && $stable(fetchKind))
    else $error("fetch word changed while stalled");
  a_kind_legal: assert property (fetchValid |-> fetchKind != 2'h3)
    else $error("illegal fetch kind");
  a_field_busy: assert property (fieldStart && !lineBusy |=>
    lineBusy)
    else $error("field start not taken");
  a_line_busy: assert property (lineReq && !lineBusy |=> lineBusy)
    else $error("line request not taken");
  a_pend_busy: assert property (lineReq && lineBusy |=> lineBusy)
    else $error("waiting line request dropped busy");
  a_bottom_vanc: assert property (bot_go |-> ##[1:4]
    (fetchValid && fetchKind == `VSA_KIND_VANC))
    else $error("bottom field did not fetch ancillary first");
  a_line_luma: assert property (line_go |-> ##[1:4]
    (fetchValid && fetchKind == `VSA_KIND_LUMA))
    else $error("line did not start with luma");
  a_luma_chroma: assert property (luma_taken |-> ##[1:3]
    (fetchValid && fetchKind == `VSA_KIND_CHROMA))
    else $error("luma not followed by chroma");
endmodule // vsa_checker
bind vsa_subpic_addr vsa_checker u_chk (.clk_sys(clk_sys), .rst(rst),
  .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData),
  .fieldStart(fieldStart), .fieldIsBottom(fieldIsBottom),
  .lineReq(lineReq), .lineBusy(lineBusy), .fetchAddr(fetchAddr),
  .fetchKind(fetchKind), .fetchValid(fetchValid), .fetchReady(fetchReady));

// ===== test/vsa_sink_model.sv
`timescale 1ns/100ps
module vsa_sink_model (
  input wire clk_sys,
  input wire rst,
  input wire stall,
  input wire slow,
  output reg fetchReady
);
  // slow mode takes a word only every other cycle, like a busy sink
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      fetchReady <= 1'b0;
    else
      fetchReady <= !stall && (!slow || !fetchReady);
  end
endmodule // vsa_sink_model

// ===== test/tb.sv
`timescale 1ns/100ps
`include "vsa_map.vh"
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic fieldStart = 1'b0, fieldIsBottom = 1'b0, lineReq = 1'b0;
  logic stall = 1'b0, slow = 1'b0, lineBusy, fetchValid, fetchReady;
  logic [7:0] regAddr = 8'h00;
  logic [10:0] lineNum = 11'h000;
  logic [31:0] regWrData = 32'h0, regRdData, fetchAddr, y;
  logic [1:0] fetchKind;
  logic [33:0] q[$];
  integer num_errors = 0, total_checks = 0, cyc = 0, n, k;
  vsa_subpic_addr DUT (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .fieldStart(fieldStart),
    .fieldIsBottom(fieldIsBottom), .lineReq(lineReq), .lineNum(lineNum),
    .lineBusy(lineBusy), .fetchAddr(fetchAddr), .fetchKind(fetchKind),
    .fetchValid(fetchValid), .fetchReady(fetchReady));
  vsa_sink_model sink (.clk_sys(clk_sys), .rst(rst), .stall(stall),
    .slow(slow), .fetchReady(fetchReady));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // record every word the sink takes; cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (fetchValid === 1'b1 && fetchReady === 1'b1)
      q.push_back({fetchKind, fetchAddr});
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  task idle;
    integer i;
    #1;
    for (i = 0; i < 50 && lineBusy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task field(input logic b);
    idle;
    @(posedge clk_sys);
    fieldStart <= 1'b1;
    fieldIsBottom <= b;
    @(posedge clk_sys);
    fieldStart <= 1'b0;
  endtask
  task line(input logic [10:0] l);
    idle;
    @(posedge clk_sys);
    lineReq <= 1'b1;
    lineNum <= l;
    @(posedge clk_sys);
    lineReq <= 1'b0;
  endtask
  task pop(input logic [1:0] kd, input logic [31:0] a);
    integer i;
    for (i = 0; i < 200 && q.size() == 0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(q.size() > 0 ? q.pop_front() : 34'bx, {kd, a});
  endtask
  // chroma areas sit 1000h above luma areas in every test
  task pair(input logic [31:0] a);
    pop(`VSA_KIND_LUMA, a);
    pop(`VSA_KIND_CHROMA, a + 32'h1000);
  endtask
  task t_regs;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h00FF01FF);
    wr(8'h00, 32'h12345678);
    rd(8'h00, 32'h12345678);
  endtask
  task t_field;
    wr(8'h08, 32'h1000);
    wr(8'h0C, 32'h3000);
    wr(8'h10, 32'h2000);
    wr(8'h14, 32'h4000);
    wr(8'h18, 32'h100);
    wr(8'h04, 32'h00200010);
    wr(8'h1C, 32'h0);
    field(1'b1);
    pop(`VSA_KIND_VANC, 32'h12345678);
    pair(32'h3020);
    rd(8'h20, 32'h00000040);
    field(1'b0);
    pair(32'h1020);
    wr(8'h1C, 32'h4);
    field(1'b0);
    pop(`VSA_KIND_VANC, 32'h12345678);
    pair(32'h1020);
  endtask
  task t_subpic;
    wr(8'h1C, 32'h3);
    for (k = 4; k <= 8; k++) begin
      wr(8'h04, 32'h00200000 | (32'h1 << k));
      y = k[0] ? 32'h3020 : 32'h1020;
      field(k[0]);
      if (k[0])
        pop(`VSA_KIND_VANC, 32'h12345678);
      pair(y);
      line(11'd5);
      pair(y + (32'd5 << k));
    end
  endtask
  task t_raster;
    for (k = 1; k <= 2; k++) begin
      wr(8'h1C, k);
      field(1'b0);
      pair(32'h1020);
      line(11'd3);
      pair(32'h1320);
    end
  endtask
  task t_latch;
    wr(8'h1C, 32'h3);
    wr(8'h04, 32'h00200010);
    field(1'b0);
    pair(32'h1020);
    wr(8'h04, 32'h00200100);
    line(11'd2);
    pair(32'h1040);
    wr(8'h04, 32'h00200030);
    field(1'b0);
    pair(32'h1020);
    line(11'd2);
    pair(32'h1040);
  endtask
  // a line asked for during a fetch waits; a newer one replaces it
  task t_pend;
    wr(8'h1C, 32'h0);
    for (k = 0; k <= 1; k++) begin
      field(1'b0);
      lineReq <= 1'b1;
      lineNum <= 11'd4;
      @(posedge clk_sys);
      lineNum <= k[0] ? 11'd6 : 11'd4;
      lineReq <= k[0];
      @(posedge clk_sys);
      lineReq <= 1'b0;
      #1 chk(34'(lineBusy), 34'h1);
      pair(32'h1020);
      pair(k[0] ? 32'h1620 : 32'h1420);
    end
  endtask
  // 32 fifo words plus the output stage hold sixteen and a half lines
  task t_fill;
    wr(8'h1C, 32'h0);
    stall <= 1'b1;
    field(1'b0);
    n = 0;
    while (n < 20 && lineBusy !== 1'b1) begin
      n = n + 1;
      line(n[10:0]);
      idle;
    end
    chk(34'(lineBusy), 34'h1);
    chk(n, 16);
    stall <= 1'b0;
    slow <= 1'b1;
    pair(32'h1020);
    for (k = 1; k <= n; k++)
      pair(32'h1020 + 32'h100 * k);
    idle;
    chk(q.size(), 0);
    chk(34'(lineBusy), 34'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_field;
    t_subpic;
    t_raster;
    t_latch;
    t_pend;
    t_fill;
    report_and_stop;
  end
endmodule // tb
